/* rtl/ebrg_pkg.sv */
// Contract
// - Request with no access in progress floats bus, selects, strobes next cycle.
// - Grant asserts on release; execution halts unless run-on mode set.
// - Run-on mode keeps executing until an external access is needed.
// - Request during access waits until the cycle after access completes.
// - Grant may fall between two accesses of one instruction.
// - Request release drops grant, re-enables drivers, resumes execution.
// - Requests honoured always, including boot and while reset active.
// - Grant-hang asserts while granted and an external access is pending.
// - After release, grant and grant-hang drop, then pending access runs.
// - Emulator enable selects emulator request, grant, reset; floats normal grant.
package ebrg_pkg;
  // ---------------------------------------------------------------
  // Synchroniser and reset values
  // ---------------------------------------------------------------
  localparam int EBRG_SYNC_STAGES = 2;
  localparam logic EBRG_RST_GRANT_N = 1'b1;
  localparam logic EBRG_RST_HANG_N = 1'b1;
  localparam logic EBRG_RST_DRIVE = 1'b1;
  localparam logic EBRG_RST_OE = 1'b1;
  localparam logic EBRG_RST_HALT = 1'b0;
  localparam logic EBRG_RST_CORE_N = 1'b0;
  // Sync idle levels: requests and emulator enable off, chip resets held
  localparam logic [4:0] EBRG_RST_SYNC = 5'h13;
endpackage

/* rtl/ebrg_core_if.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Synchronised request levels between top and synchroniser
// ---------------------------------------------------------------
interface ebrg_core_if;
  logic bus_request_n;
  logic emu_bus_request_n;
  logic emu_reset_n;
  logic reset_n;
  logic emulator_enable;
  modport sync (output bus_request_n, emu_bus_request_n, emu_reset_n,
    reset_n, emulator_enable);
  modport core (input bus_request_n, emu_bus_request_n, emu_reset_n,
    reset_n, emulator_enable);
endinterface
`default_nettype wire

/* rtl/ebrg_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module ebrg_sync import ebrg_pkg::*; (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [4:0] raw_in,
  ebrg_core_if.sync sync_if
);
  typedef struct packed {
    logic [4:0] meta;
    logic [4:0] stable;
  } ebrg_sync_t;
  ebrg_sync_t state;
  ebrg_sync_t next_state;
  always_comb begin
    next_state = state;
    next_state.meta = raw_in;
    next_state.stable = state.meta;
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= '{meta: EBRG_RST_SYNC, stable: EBRG_RST_SYNC};
    end else begin
      state <= next_state;
    end
  end
  assign sync_if.bus_request_n = state.stable[0];
  assign sync_if.emu_bus_request_n = state.stable[1];
  assign sync_if.emu_reset_n = state.stable[2];
  assign sync_if.reset_n = state.stable[3];
  assign sync_if.emulator_enable = ~state.stable[4];
endmodule // ebrg_sync
`default_nettype wire

/* rtl/ebrg_arbiter.sv */
`timescale 1ns/1ps
`default_nettype none
module ebrg_arbiter import ebrg_pkg::*; (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic bus_request_n_in,
  input wire logic emu_bus_request_n_in,
  input wire logic emulator_enable_n_in,
  input wire logic reset_n_in,
  input wire logic emu_reset_n_in,
  input wire logic run_on_mode_in,
  input wire logic ext_access_busy_in,
  input wire logic ext_access_done_in,
  input wire logic ext_access_need_in,
  input wire logic byte_memory_dma_access_need_in,
  output logic bus_grant_n_out,
  output logic bus_grant_oe_out,
  output logic emu_bus_grant_n_out,
  output logic grant_hang_n_out,
  output logic mem_drive_en_out,
  output logic core_halt_out,
  output logic core_reset_n_out
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum {EBRG_OWNED, EBRG_GRANTED} ebrg_mode_t;
  typedef struct packed {
    ebrg_mode_t mode;
    logic grant_n;
    logic grant_oe;
    logic emu_grant_n;
    logic hang_n;
    logic drive;
    logic halt;
    logic rst_n;
  } ebrg_state_t;
  ebrg_state_t state;
  ebrg_state_t next_state;
  ebrg_core_if sig_if ();
  logic req;
  logic access_live;
  logic need;

  ebrg_sync u_sync (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .raw_in({emulator_enable_n_in, reset_n_in, emu_reset_n_in,
      emu_bus_request_n_in, bus_request_n_in}),
    .sync_if(sig_if.sync)
  );

  // ---------------------------------------------------------------
  // Request source and grant decision
  // ---------------------------------------------------------------
  always_comb begin
    req = sig_if.emulator_enable ? !sig_if.emu_bus_request_n
      : !sig_if.bus_request_n;
    // Access still running unless it finishes this cycle
    access_live = ext_access_busy_in && !ext_access_done_in;
    need = ext_access_need_in || byte_memory_dma_access_need_in;
    next_state = state;
    next_state.rst_n = sig_if.emulator_enable ? sig_if.emu_reset_n
      : sig_if.reset_n;
    case (state.mode)
      EBRG_OWNED: begin
        // Reset does not gate this path
        if (req && !access_live) begin
          next_state.mode = EBRG_GRANTED;
          next_state.drive = 1'b0;
          next_state.halt = !run_on_mode_in;
        end
      end
      EBRG_GRANTED: begin
        if (!req) begin
          next_state.mode = EBRG_OWNED;
          next_state.drive = 1'b1;
          next_state.halt = 1'b0;
        end else begin
          next_state.halt = !run_on_mode_in || need;
        end
      end
      default: begin
        next_state.mode = EBRG_OWNED;
      end
    endcase
    next_state.grant_n = !(next_state.mode == EBRG_GRANTED) ||
      sig_if.emulator_enable;
    next_state.emu_grant_n = !(next_state.mode == EBRG_GRANTED) ||
      !sig_if.emulator_enable;
    next_state.grant_oe = !sig_if.emulator_enable;
    next_state.hang_n = !(next_state.mode == EBRG_GRANTED && need);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= '{mode: EBRG_OWNED, grant_n: EBRG_RST_GRANT_N,
        grant_oe: EBRG_RST_OE, emu_grant_n: EBRG_RST_GRANT_N,
        hang_n: EBRG_RST_HANG_N, drive: EBRG_RST_DRIVE,
        halt: EBRG_RST_HALT, rst_n: EBRG_RST_CORE_N};
    end else begin
      state <= next_state;
    end
  end

  assign bus_grant_n_out = state.grant_n;
  assign bus_grant_oe_out = state.grant_oe;
  assign emu_bus_grant_n_out = state.emu_grant_n;
  assign grant_hang_n_out = state.hang_n;
  assign mem_drive_en_out = state.drive;
  assign core_halt_out = state.halt;
  assign core_reset_n_out = state.rst_n;
endmodule // ebrg_arbiter
`default_nettype wire

/* tb/ebrg_master.sv */
`timescale 1ns/1ps
`default_nettype none
module ebrg_master (
  input wire logic clk_in, go_in, grant_n_in, hang_n_in,
  input wire logic [3:0] hold_in,
  output logic req_n_out);
  logic [4:0] s = 5'h00;
  assign req_n_out = !go_in | s[4];
  always @(posedge clk_in)
    if (!go_in) s <= 5'h00;
    else if (!grant_n_in && !s[4])
      s <= (s[3:0] == hold_in || !hang_n_in) ? 5'h10 : s + 5'h01;
endmodule // ebrg_master
`default_nettype wire

/* tb/ebrg_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module ebrg_chk (
  input wire logic clk_in, arst_n_in, bus_request_n_in, emulator_enable_n_in,
  input wire logic run_on_mode_in, ext_access_busy_in, ext_access_done_in,
  input wire logic ext_access_need_in, byte_memory_dma_access_need_in, bus_grant_n_out,
  input wire logic bus_grant_oe_out, grant_hang_n_out, mem_drive_en_out,
  input wire logic core_halt_out);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  logic [2:0] e;
  wire logic m = emulator_enable_n_in, o = &e & m, g = ~bus_grant_n_out;
  wire logic b = ext_access_busy_in, h = core_halt_out, n = grant_hang_n_out;
  always_ff @(posedge clk_in or negedge arst_n_in)
    if (!arst_n_in) e <= 3'h0; else e <= {e[1:0], m};
  property p_dr; o |-> mem_drive_en_out == !g; endproperty
  a_dr: assert property (p_dr) else $error("drive");
  property p_gn; o && !$past(bus_request_n_in, 3) && !$past(b) |-> g; endproperty
  a_gn: assert property (p_gn) else $error("grant");
  property p_rl; o && $past(bus_request_n_in, 3) |-> !g && n && !h; endproperty
  a_rl: assert property (p_rl) else $error("release");
  property p_wt; o && !$past(g) && $past(b & ~ext_access_done_in) |-> !g;
  endproperty
  a_wt: assert property (p_wt) else $error("wait");
  property p_ht; o && g && !$past(run_on_mode_in) |-> h; endproperty
  a_ht: assert property (p_ht) else $error("halt");
  property p_ro; o && g && $past(g && run_on_mode_in) |-> h == $past(
    ext_access_need_in); endproperty
  a_ro: assert property (p_ro) else $error("run on");
  property p_hg; o && g && $past(g && (ext_access_need_in |
    byte_memory_dma_access_need_in)) |-> !n; endproperty
  a_hg: assert property (p_hg) else $error("hang");
  property p_em; !m && e == 3'h0 |-> !bus_grant_oe_out && !g; endproperty
  a_em: assert property (p_em) else $error("emulator");
endmodule // ebrg_chk
bind ebrg_arbiter ebrg_chk u_chk (.*);
`default_nettype wire

/* tb/external_bus_request_grant_test.sv */
`timescale 1ns/1ps
`default_nettype none
module external_bus_request_grant_test;
  logic clk_in = 0, arst_n_in = 0, go = 0, en = 1, bz = 0, dn = 0, nd = 0;
  logic bd = 0, rq, gn, oe, eg, hn, dv, ht, cr;
  logic [15:0] r = 16'h002a;
  int err_count = 0, cmp_count = 0, cyc = 0, n;
  always #4 clk_in = ~clk_in;
  ebrg_master u_m (.clk_in, .go_in(go), .grant_n_in(gn), .hang_n_in(hn),
    .hold_in(r[7:4]), .req_n_out(rq));
  ebrg_arbiter u_dut (.clk_in, .arst_n_in, .bus_request_n_in(rq),
    .emu_bus_request_n_in(en), .emulator_enable_n_in(en), .reset_n_in(r[8]),
    .emu_reset_n_in(r[8]), .run_on_mode_in(r[3]), .ext_access_busy_in(bz),
    .ext_access_done_in(dn), .ext_access_need_in(nd),
    .byte_memory_dma_access_need_in(bd), .bus_grant_n_out(gn), .bus_grant_oe_out(oe),
    .emu_bus_grant_n_out(eg), .grant_hang_n_out(hn),
    .mem_drive_en_out(dv), .core_halt_out(ht), .core_reset_n_out(cr));
  function automatic logic [15:0] nx(logic [15:0] v);
    return {v[14:0], ^(v & 16'hb400)};
  endfunction
  function automatic int lat(int c);
    return c > 3 ? c : 3;
  endfunction
  task automatic chk(logic [7:0] g, x);
    cmp_count++;
    if (g !== x) begin
      err_count++;
      $display("unexpected %0t %h %h", $time, g, x);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic step;
    @(posedge clk_in);
    #1;
  endtask
  always @(posedge clk_in) if (++cyc > 3000) begin
    err_count++;
    give_verdict;
  end
  initial begin
    repeat (3) step;
    chk({gn, oe, hn, dv, ht, cr}, 8'h3c);
    arst_n_in = 1;
    repeat (40) begin
      r = nx(r);
      go = 1;
      for (n = 0; gn && n < 20; n++) begin
        bz = n < r[2:0];
        dn = n + 1 == r[2:0];
        step;
      end
      chk(8'(n), 8'(lat(r[2:0])));
      chk({dv, eg, oe}, 8'h03);
      {bz, dn, nd, bd} = {2'h0, r[9], r[10] & ~r[3]};
      step;
      chk({hn, ht}, {~(nd | bd), ~r[3] | nd});
      chk(cr, r[8]);
      for (int i = 0; !gn && i < 40; i++) step;
      chk({gn, hn, dv, ht}, 8'h0e);
      {go, nd, bd} = 3'h0;
      step;
    end
    en = 0;
    repeat (5) step;
    chk({oe, gn, eg, cr}, {3'h2, r[8]});
    give_verdict;
  end
endmodule // external_bus_request_grant_test
`default_nettype wire
